// >>> common/rwrs_pkg.sv
// rwrs_pkg: constants, pin bundles and state types of the wide ROM read sequencer
// assumes a single 20 MHz processor clock shared by every rwrs module
package rwrs_pkg;

    // clock and ROM access time
    localparam int CLK_PERIOD_NS  = 50;
    localparam int ROM_ACCESS_NS  = 170;
    // least time rounds up to whole cycles, never below one
    localparam int ROM_ACCESS_CYC = ((ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                    ((ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // widths and layout
    localparam int ROM_ADDR_W  = 16;
    localparam int ADDR_HI_W   = 14;          // processor address bits 16 down to 3
    localparam int WORD_W      = 16;
    localparam int WORDS       = 4;
    localparam int DWORD_W     = WORD_W * WORDS;
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_W      = ADDR_HI_W + 5;

    // encodings
    localparam logic       RNW_READ   = 1'b1;
    localparam logic [1:0] FIRST_WORD = 2'h0;
    localparam logic [1:0] LAST_WORD  = 2'h3;
    localparam logic [1:0] WORD_STEP  = 2'h1;
    localparam logic [3:0] CNT_STEP   = 4'h1;

    // processor and decode pins, all active levels as named
    typedef struct packed {
        logic                 transfer_start_n;
        logic                 data_bus_busy_n;
        logic                 read_not_write;
        logic                 rom_relocated;
        logic                 rom_select;
        logic [ADDR_HI_W-1:0] addr_hi;
    } rwrs_cpu_t;

    // ROM side pins
    typedef struct packed {
        logic [ROM_ADDR_W-1:0] rom_addr;
        logic [WORDS-1:0]      latch_pair_enable;
    } rwrs_rom_t;

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_QUAL, SEQ_SEL, SEQ_W0, SEQ_W1, SEQ_W2, SEQ_W3, SEQ_DECIDE
    } rwrs_seq_t;

    typedef enum logic [3:0] {
        CNT_IDLE, CNT_1, CNT_2, CNT_3, CNT_4, CNT_5, CNT_6, CNT_7, CNT_8, CNT_9, CNT_10
    } rwrs_cnt_t;

endpackage

// >>> hdl/rwrs_fifo.sv
// rwrs_fifo: flip-flop FIFO with a registered output stage
// assumes source and sink on the same clock; valid/ready handshake on both sides
`timescale 1ns/1ps
`default_nettype none
module rwrs_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0]    cnt_r, cnt_nxt;
    logic             ov_r, ov_nxt;
    logic [WIDTH-1:0] od_r, od_nxt;
    logic             push, pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    always_comb begin
        in_ready = (cnt_r != CW'(DEPTH));
        push     = in_valid && in_ready;
        // memory feeds the output stage whenever that stage is empty or leaving
        pop      = (cnt_r != '0) && (!ov_r || out_ready);
        wr_nxt   = push ? wrap_inc(wr_r) : wr_r;
        rd_nxt   = pop ? wrap_inc(rd_r) : rd_r;
        cnt_nxt  = cnt_r + CW'(push) - CW'(pop);
        ov_nxt   = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
        od_nxt   = pop ? mem_r[rd_r] : od_r;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            ov_r  <= 1'b0;
            od_r  <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            ov_r  <= ov_nxt;
            od_r  <= od_nxt;
        end
    end

    // storage has no reset; words are only read after being written
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    assign out_valid = ov_r;
    assign out_data  = od_r;
endmodule
`default_nettype wire

// >>> hdl/rwrs_top.sv
// rwrs_top: serves 64-bit processor reads from a 16-bit ROM in four word fetches
// assumes external decode drives rom_select and the ROM enables; acks other than early_ack_n are formed outside
`timescale 1ns/1ps
`default_nettype none
module rwrs_top
    import rwrs_pkg::*;
#(
    parameter int FIFO_D = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // processor bus and decode
    input  wire rwrs_cpu_t           cpu_in,
    output logic                     early_ack_n,
    output logic [DWORD_W-1:0]       cpu_data_o,
    output logic                     cpu_data_oe,
    // ROM and latch pairs
    input  wire logic [WORD_W-1:0]   rom_data,
    output rwrs_rom_t                rom_out,
    // buffered double words
    output logic                     dword_valid,
    input  wire logic                dword_ready,
    output logic [DWORD_W-1:0]       dword_data
);
    // pin synchronisers: stage 1 only feeds stage 2
    rwrs_cpu_t         cpu_m_r, cpu_s;
    logic [WORD_W-1:0] dat_m_r, dat_s;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_m_r <= '{transfer_start_n: 1'b1, data_bus_busy_n: 1'b1, default: '0};
            cpu_s   <= '{transfer_start_n: 1'b1, data_bus_busy_n: 1'b1, default: '0};
            dat_m_r <= '0;
            dat_s   <= '0;
        end else begin
            cpu_m_r <= cpu_in;
            cpu_s   <= cpu_m_r;
            dat_m_r <= rom_data;
            dat_s   <= dat_m_r;
        end
    end

    logic busy_gone;
    assign busy_gone = cpu_s.data_bus_busy_n;

    function automatic logic [1:0] word_of(input rwrs_seq_t s);
        case (s)
            SEQ_W1:  word_of = FIRST_WORD + WORD_STEP;
            SEQ_W2:  word_of = FIRST_WORD + WORD_STEP + WORD_STEP;
            SEQ_W3:  word_of = LAST_WORD;
            default: word_of = FIRST_WORD;
        endcase
    endfunction

    function automatic logic is_fetch(input rwrs_seq_t s);
        is_fetch = (s == SEQ_W0) || (s == SEQ_W1) || (s == SEQ_W2) || (s == SEQ_W3);
    endfunction

    // sequencing_fsm
    rwrs_seq_t           seq_r, seq_nxt;
    logic                run_r, run_nxt;
    logic [1:0]          low_r, low_nxt;
    logic                next_r;
    logic                push_r, push_nxt;
    logic                fifo_in_ready;

    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_IDLE:   if (!cpu_s.transfer_start_n) seq_nxt = SEQ_QUAL;
            SEQ_QUAL:   if (!cpu_s.rom_relocated && cpu_s.read_not_write == RNW_READ)
                            seq_nxt = SEQ_SEL;
            SEQ_SEL: begin
                // wait for buffer room so a finished double word is never dropped
                if (!cpu_s.rom_select) seq_nxt = SEQ_IDLE;
                else if (fifo_in_ready) seq_nxt = SEQ_W0;
            end
            SEQ_W0:     if (next_r) seq_nxt = SEQ_W1;
            SEQ_W1:     if (next_r) seq_nxt = SEQ_W2;
            SEQ_W2:     if (next_r) seq_nxt = SEQ_W3;
            SEQ_W3:     if (next_r) seq_nxt = SEQ_DECIDE;
            SEQ_DECIDE: begin
                if (!cpu_s.transfer_start_n) seq_nxt = SEQ_SEL;
                else if (!cpu_s.data_bus_busy_n) seq_nxt = SEQ_QUAL;
                else seq_nxt = SEQ_IDLE;
            end
            default:    seq_nxt = SEQ_IDLE;
        endcase
        // busy is seen one cycle after start, so a refused access parked in qualify
        // is released by busy negation too; the decision state weighs busy itself
        if (busy_gone && seq_r != SEQ_IDLE && seq_r != SEQ_DECIDE)
            seq_nxt = SEQ_IDLE;
        // one pulse on entry, so the fourth fetch never restarts the counter
        run_nxt  = is_fetch(seq_nxt) && (seq_nxt != seq_r);
        low_nxt  = word_of(seq_nxt);
        push_nxt = (seq_r == SEQ_W3) && (seq_nxt == SEQ_DECIDE);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seq_r  <= SEQ_IDLE;
            run_r  <= 1'b0;
            low_r  <= FIRST_WORD;
            push_r <= 1'b0;
        end else begin
            seq_r  <= seq_nxt;
            run_r  <= run_nxt;
            low_r  <= low_nxt;
            push_r <= push_nxt;
        end
    end

    // wait_counter_fsm: sees only run, the low address bits and busy
    rwrs_cnt_t cnt_r, cnt_nxt;
    logic      open_r, open_nxt;
    logic      next_nxt;
    logic      eack_n_r, eack_n_nxt;

    always_comb begin
        case (cnt_r)
            CNT_IDLE: cnt_nxt = run_r ? CNT_1 : CNT_IDLE;
            CNT_10:   cnt_nxt = CNT_IDLE;
            default:  cnt_nxt = rwrs_cnt_t'(cnt_r + CNT_STEP);
        endcase
        if (busy_gone) cnt_nxt = CNT_IDLE;
        // latch held open CNT_1..CNT_9, well past the ROM access time
        open_nxt   = (cnt_nxt != CNT_IDLE) && (cnt_nxt != CNT_10);
        next_nxt   = (cnt_r == CNT_9) && (cnt_nxt == CNT_10);
        eack_n_nxt = !((cnt_r == CNT_7) && (cnt_nxt == CNT_8) && low_r == LAST_WORD);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r    <= CNT_IDLE;
            open_r   <= 1'b0;
            next_r   <= 1'b0;
            eack_n_r <= 1'b1;
        end else begin
            cnt_r    <= cnt_nxt;
            open_r   <= open_nxt;
            next_r   <= next_nxt;
            eack_n_r <= eack_n_nxt;
        end
    end

    // latch pairs, ROM address and data drive
    logic [WORDS-1:0]      lpe_r, lpe_nxt;
    logic [WORD_W-1:0]     word_r [WORDS];
    logic [WORD_W-1:0]     word_nxt [WORDS];
    logic [ROM_ADDR_W-1:0] addr_r, addr_nxt;
    logic                  oe_r, oe_nxt;

    always_comb begin
        lpe_nxt = '0;
        if (open_r) lpe_nxt[low_r] = 1'b1;
        for (int i = 0; i < WORDS; i++) begin
            word_nxt[i] = lpe_r[i] ? dat_s : word_r[i];
        end
        addr_nxt = {cpu_s.addr_hi, low_nxt};
        oe_nxt   = cpu_s.rom_select && (is_fetch(seq_r) || seq_r == SEQ_DECIDE);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lpe_r  <= '0;
            addr_r <= '0;
            oe_r   <= 1'b0;
            for (int i = 0; i < WORDS; i++) word_r[i] <= '0;
        end else begin
            lpe_r  <= lpe_nxt;
            addr_r <= addr_nxt;
            oe_r   <= oe_nxt;
            for (int i = 0; i < WORDS; i++) word_r[i] <= word_nxt[i];
        end
    end

    logic [DWORD_W-1:0] dword_cat;
    assign dword_cat = {word_r[3], word_r[2], word_r[1], word_r[0]};

    rwrs_fifo #(
        .WIDTH (DWORD_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (dword_cat),
        .out_valid (dword_valid),
        .out_ready (dword_ready),
        .out_data  (dword_data)
    );

    assign early_ack_n               = eack_n_r;
    assign cpu_data_o                = dword_cat;
    assign cpu_data_oe               = oe_r;
    assign rom_out                   = '{rom_addr: addr_r, latch_pair_enable: lpe_r};

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    start_to_qual_a: assert property (seq_r == SEQ_IDLE && !cpu_s.transfer_start_n |=> seq_r == SEQ_QUAL)
        else $error("start did not leave idle");
    busy_abort_a: assert property (busy_gone && seq_r != SEQ_IDLE && seq_r != SEQ_DECIDE
                                   |=> seq_r == SEQ_IDLE && cnt_r == CNT_IDLE)
        else $error("busy negation did not idle both machines");
    qual_block_a: assert property (seq_r == SEQ_QUAL && (cpu_s.rom_relocated || !cpu_s.read_not_write)
                                   |=> seq_r != SEQ_SEL)
        else $error("access started on write or relocation");
    select_gate_a: assert property (seq_r == SEQ_SEL && !cpu_s.rom_select && !busy_gone |=> seq_r == SEQ_IDLE)
        else $error("missing select did not return idle");
    run_pulse_a: assert property (run_r |=> !run_r ##0 cnt_r == CNT_1 || busy_gone)
        else $error("run not a single pulse starting the counter");
    no_fifth_a: assert property (seq_r == SEQ_W3 && $past(seq_r) == SEQ_W3 |-> !run_r)
        else $error("run seen during fourth fetch");
    next_step_a: assert property (cnt_r == CNT_9 && !busy_gone |=> next_r ##1 !next_r)
        else $error("next not pulsed on nine to ten");
    early_ack_a: assert property (!eack_n_r |-> cnt_r == CNT_8 && low_r == LAST_WORD ##1 eack_n_r)
        else $error("early ack outside last word step eight");
    addr_low_a: assert property (is_fetch(seq_r) |-> addr_r[1:0] == word_of(seq_r))
        else $error("low address differs from fetch state");
    one_latch_a: assert property ($onehot0(lpe_r))
        else $error("more than one latch pair open");
    access_time_a: assert property ($fell(open_r) && !busy_gone |-> $past(open_r, ROM_ACCESS_CYC))
        else $error("latch closed before ROM access time");

    full_read_c: cover property (seq_r == SEQ_W3 ##1 seq_r == SEQ_DECIDE && push_r);
    burst_c:     cover property (seq_r == SEQ_DECIDE ##1 seq_r == SEQ_QUAL);
    back2back_c: cover property (seq_r == SEQ_DECIDE ##1 seq_r == SEQ_SEL);
    abort_c:     cover property (is_fetch(seq_r) ##1 seq_r == SEQ_IDLE);
    decide_idle_c: cover property (seq_r == SEQ_DECIDE ##1 seq_r == SEQ_IDLE);
endmodule
`default_nettype wire

// >>> verification/rwrs_rom_model.sv
// rwrs_rom_model: 16-bit ROM seen by the sequencer, slow access
// assumes address and select change just after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module rwrs_rom_model #(
    parameter int ACC_CYC = 5
) (
    // clock
    input  wire logic        mclk,
    // ROM pins
    input  wire logic [15:0] rom_addr,
    input  wire logic        rom_select,
    output logic      [15:0] rom_data
);
    logic [15:0] last_r = 16'h0000;
    logic [15:0] data_r = 16'h0000;
    int          cnt_r  = 0;
    assign rom_data = data_r;
    // toggles until access time is over, so stale data never passes
    always @(posedge mclk) begin
        last_r <= rom_addr;
        if (!rom_select || rom_addr != last_r) begin
            cnt_r  <= 1;
            data_r <= ~data_r;
        end else if (cnt_r < ACC_CYC) begin
            cnt_r  <= cnt_r + 1;
            data_r <= ~data_r;
        end else begin
            data_r <= {rom_addr[7:0], rom_addr[15:8]} ^ 16'h5A3C;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// tb_top: self-checking bench for the wide ROM read sequencer
// assumes rwrs_top and the ROM model share one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rwrs_pkg::*;
();
    logic             mclk = 1'b0;
    logic             rst  = 1'b1;
    rwrs_cpu_t        cpu;
    rwrs_rom_t        rom_out;
    logic             dword_ready;
    logic             early_ack_n;
    logic             cpu_data_oe;
    logic             dword_valid;
    logic [63:0]      cpu_data_o;
    logic [63:0]      dword_data;
    logic [15:0]      rom_data;
    logic [15:0]      seq    = 16'h0000;
    logic [3:0]       lpe_r  = 4'h0;
    int               errors = 0;
    int               tests_run = 0;
    int               n_early = 0;
    int               n_open = 0;
    int               gap = 0;
    time              t_last = 0;

    always #25 mclk = ~mclk;

    rwrs_top #(.FIFO_D(FIFO_DEPTH)) DUT (
        .mclk(mclk), .rst(rst), .cpu_in(cpu), .early_ack_n(early_ack_n),
        .cpu_data_o(cpu_data_o), .cpu_data_oe(cpu_data_oe), .rom_data(rom_data),
        .rom_out(rom_out), .dword_valid(dword_valid), .dword_ready(dword_ready),
        .dword_data(dword_data)
    );

    rwrs_rom_model ROM (
        .mclk(mclk), .rom_addr(rom_out.rom_addr), .rom_select(cpu.rom_select), .rom_data(rom_data)
    );

    function automatic logic [15:0] word_of(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h5A3C;
    endfunction

    function automatic logic [63:0] dword_of(input logic [13:0] h);
        return {word_of({h, 2'h3}), word_of({h, 2'h2}), word_of({h, 2'h1}), word_of({h, 2'h0})};
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // sampled mid-cycle, where the registered outputs have settled
    always @(negedge mclk) begin
        if (early_ack_n === 1'b0)
            n_early <= n_early + 1;
        if (rom_out.latch_pair_enable != 4'h0 && lpe_r == 4'h0) begin
            n_open <= n_open + 1;
            gap    <= int'(($time - t_last) / 50);
            t_last <= $time;
        end
        if (rom_out.latch_pair_enable != 4'h0 && rom_out.latch_pair_enable != lpe_r)
            seq <= {seq[11:0], rom_out.latch_pair_enable};
        lpe_r <= rom_out.latch_pair_enable;
    end

    always @(negedge mclk)
        if (rom_out.latch_pair_enable != 4'h0)
            check(64'(rom_out.latch_pair_enable & (rom_out.latch_pair_enable - 4'h1)), 64'h0);

    task automatic start_xfer(input logic [13:0] a, input logic rnw, input logic rel, input logic sel);
        @(negedge mclk);
        cpu = '{1'b0, 1'b1, rnw, rel, sel, a};
        @(negedge mclk);
        cpu.transfer_start_n = 1'b1;
        cpu.data_bus_busy_n  = 1'b0;
    endtask

    task automatic end_xfer();
        @(negedge mclk);
        cpu.data_bus_busy_n = 1'b1;
        cpu.rom_select      = 1'b0;
        repeat (12) @(negedge mclk);
    endtask

    task automatic pop(input logic [63:0] exp);
        for (int i = 0; i < 40 && dword_valid !== 1'b1; i++) @(negedge mclk);
        check(64'(dword_valid), 64'h1);
        check(dword_data, exp);
        dword_ready = 1'b1;
        @(negedge mclk);
        dword_ready = 1'b0;
        @(negedge mclk);
    endtask

    task automatic t_read(input logic [13:0] a);
        int n0;
        n0 = n_early;
        start_xfer(a, RNW_READ, 1'b0, 1'b1);
        for (int i = 0; i < 300 && n_early == n0; i++) @(negedge mclk);
        check(64'(cpu_data_oe), 64'h1);
        // select drops before the decision, so the burst path ends idle
        cpu.rom_select = 1'b0;
        pop(dword_of(a));
        check(cpu_data_o, dword_of(a));
        check(64'(seq), 64'h1248);
        check(64'(gap), 64'hB);
        end_xfer();
        check(64'(n_early - n0), 64'h1);
        check(64'(cpu_data_oe), 64'h0);
    endtask

    task automatic t_b2b(input logic [13:0] a, input logic [13:0] b);
        int n0;
        n0 = n_early;
        start_xfer(a, RNW_READ, 1'b0, 1'b1);
        for (int i = 0; i < 300 && n_early == n0; i++) @(negedge mclk);
        // next start lands on the decision state of the first transfer
        cpu = '{1'b0, 1'b1, RNW_READ, 1'b0, 1'b1, b};
        @(negedge mclk);
        cpu.transfer_start_n = 1'b1;
        cpu.data_bus_busy_n  = 1'b0;
        for (int i = 0; i < 300 && n_early == n0 + 1; i++) @(negedge mclk);
        // busy and select drop together, so the decision takes the idle branch
        cpu.data_bus_busy_n = 1'b1;
        cpu.rom_select      = 1'b0;
        pop(dword_of(a));
        pop(dword_of(b));
        end_xfer();
        check(64'(n_early - n0), 64'h2);
    endtask

    task automatic t_refuse(input logic rnw, input logic rel, input logic sel);
        int n0;
        n0 = n_open;
        start_xfer(14'h0155, rnw, rel, sel);
        repeat (80) @(negedge mclk);
        check(64'(n_open - n0), 64'h0);
        check(64'(dword_valid), 64'h0);
        end_xfer();
    endtask

    task automatic t_abort();
        int n0;
        n0 = n_early;
        start_xfer(14'h2AAA, RNW_READ, 1'b0, 1'b1);
        for (int i = 0; i < 100 && rom_out.latch_pair_enable === 4'h0; i++) @(negedge mclk);
        repeat (20) @(negedge mclk);
        cpu.data_bus_busy_n = 1'b1;
        repeat (6) @(negedge mclk);
        check(64'(rom_out.latch_pair_enable), 64'h0);
        repeat (60) @(negedge mclk);
        check(64'(n_early - n0), 64'h0);
        check(64'(dword_valid), 64'h0);
        end_xfer();
    endtask

    task automatic t_burst();
        int n0;
        int n1;
        n0 = n_early;
        start_xfer(14'h3C0F, RNW_READ, 1'b0, 1'b1);
        repeat (1500) @(negedge mclk);
        n1 = n_early;
        repeat (120) @(negedge mclk);
        check(64'(n_early), 64'(n1));
        check(64'(n1 - n0 >= FIFO_DEPTH), 64'h1);
        end_xfer();
        for (int i = 0; i < n1 - n0; i++)
            pop(dword_of(14'h3C0F));
        repeat (4) @(negedge mclk);
        check(64'(dword_valid), 64'h0);
    endtask

    initial begin
        cpu         = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 14'h0000}; // busy negated during reset
        dword_ready = 1'b0;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        check(64'(early_ack_n), 64'h1);
        check(64'(dword_valid), 64'h0);
        t_read(14'h1234);
        t_refuse(1'b0, 1'b0, 1'b1);
        t_refuse(RNW_READ, 1'b1, 1'b1);
        t_refuse(RNW_READ, 1'b0, 1'b0);
        t_abort();
        t_read(14'h3FFF);
        t_b2b(14'h0A5F, 14'h15A0);
        t_burst();
        t_read(14'h0000);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
